// ### hw/mcw_decode_pkg.sv
// Field positions, reset values and cycle timing for the microword control decoder.
package mcw_decode_pkg;
    localparam int          WORD_W          = 33;
    localparam int          CLK_LEN_HI      = 32;
    localparam int          CLK_LEN_LO      = 31;
    localparam int          IRQ_EN_BIT      = 30;
    localparam int          FC_N_BIT        = 29;
    localparam int          SEQ_HI          = 28;
    localparam int          SEQ_LO          = 23;
    localparam int          HOST_IRQ_BIT    = 28;
    localparam int          SIGN_EXT_BIT    = 27;
    localparam int          INIT_BIT        = 26;
    localparam int          IRQ_BASE_BIT    = 25;
    localparam int          KEEP_HI         = 28;
    localparam int          KEEP_LO         = 27;
    localparam int          TEST_HI         = 22;
    localparam int          TEST_LO         = 19;
    localparam int          OPC_LD_BIT      = 18;
    localparam int          MACRO_LD_BIT    = 17;
    localparam int          BRANCH_EN_N_BIT = 16;
    localparam int          BRANCH_HI       = 15;
    localparam int          BRANCH_LO       = 0;
    localparam logic [1:0]  TEST_KEEP_PAT   = 2'h3;
    // Reset word: force-continue and branch enable both inactive, nothing strobed.
    localparam logic [32:0] PIPE_RESET      = 33'h020010000;
    // Machine cycle lengths in system clocks: 3, 4, 5, 6 give 1, 1.33, 1.66, 2 times.
    localparam logic [2:0]  TICKS_NORMAL    = 3'h3;
    localparam logic [2:0]  TICKS_X133      = 3'h4;
    localparam logic [2:0]  TICKS_X166      = 3'h5;
    localparam logic [2:0]  TICKS_X200      = 3'h6;
endpackage

// ### hw/cycle_length_timer.sv
// Machine cycle timer that stretches each cycle by the selected length code.
`timescale 1ns/1ps
module cycle_length_timer (
    input  wire logic       clk_sys,             // system clock
    input  wire logic       rst,                 // synchronous reset, active high
    input  wire logic [1:0] length_select,       // length code of the current cycle
    output logic            cycle_end            // high on the last clock of a cycle
);
    logic [2:0] count_r;
    logic [2:0] ticks;

    always_comb begin
        unique case (length_select)
            2'h0: ticks = mcw_decode_pkg::TICKS_NORMAL;
            2'h1: ticks = mcw_decode_pkg::TICKS_X133;
            2'h2: ticks = mcw_decode_pkg::TICKS_X166;
            2'h3: ticks = mcw_decode_pkg::TICKS_X200;
        endcase
    end

    assign cycle_end = (count_r == ticks - 3'h1);

    always_ff @(posedge clk_sys) begin
        if (rst || cycle_end) begin
            count_r <= 3'h0;
        end else begin
            count_r <= count_r + 3'h1;
        end
    end
endmodule // cycle_length_timer

// ### hw/microword_control_field_decoder.sv
// Control pipeline register and decoder for the control section of the microword.
//
// Function
// - Bit 29 high selects primary field meaning, low selects alternate meaning.
// - Primary meaning: bits 28:23 form the six-bit sequencer opcode, bit 28 MSB.
// - Alternate: bits 28..25 are host irq, sign extend, initialize, irq base load.
// - Primary test meaning: bits 22:19 form the four-bit test select, bit 22 MSB.
// - Test select kept only when force-continue inactive and bits 28:27 equal 11.
// - Otherwise bits 22:19 become the four-bit interrupt controller opcode.
// - Cycle length code stretches the machine cycle by 1, 1.33, 1.66 or 2.
// - Bit 30 gates sequencer interrupt acceptance for each cycle it is set.
// - While force-continue is active the sequencer executes continue.
// - Initialize strobe loads the pipeline from the initialize register at the next cycle end.
`timescale 1ns/1ps
module microword_control_field_decoder (
    input  wire logic        clk_sys,              // system clock, 50 MHz
    input  wire logic        rst,                  // synchronous reset, active high
    input  wire logic [32:0] ctrl_store_word,      // next control word from control store
    input  wire logic [32:0] init_word,            // control store initialize register
    output logic             machine_cycle_end,    // last system clock of a machine cycle
    output logic [32:0]      pipe_word,            // control pipeline register contents
    output logic [1:0]       cycle_length_select,  // stretch code of the current cycle
    output logic             irq_accept_enable,    // sequencer interrupt acceptance gate
    output logic             force_continue_n,     // force-continue flag, active low
    output logic             sequencer_continue,   // sequencer must execute continue
    output logic [5:0]       sequencer_opcode,     // sequencer instruction code
    output logic             host_irq_req,         // interrupt request to the host
    output logic             a_bus_sign_extend,    // sign extend data toward the A bus
    output logic             init_strobe,          // initialize requested this cycle
    output logic             irq_base_load,        // load interrupt base address register
    output logic [3:0]       test_select,          // sequencer test condition select
    output logic             test_select_valid,    // test select meaning in force
    output logic [3:0]       irq_ctrl_opcode,      // interrupt controller instruction
    output logic             irq_ctrl_valid,       // interrupt controller meaning in force
    output logic             operand_counter_load, // load the operand counter
    output logic             macro_opcode_load,    // load the macro opcode register
    output logic [15:0]      d_bus_out,            // branch address toward the data bus
    output logic             d_bus_oe_n            // data bus drive enable, active low
);
    logic [32:0] pipe_r;
    logic [32:0] pipe_nxt;
    logic        cycle_end;

    logic [1:0]  cycle_length_select_r;
    logic        irq_accept_enable_r;
    logic        force_continue_n_r;
    logic [5:0]  sequencer_opcode_r;
    logic        host_irq_req_r;
    logic        a_bus_sign_extend_r;
    logic        init_strobe_r;
    logic        irq_base_load_r;
    logic [3:0]  test_select_r;
    logic        test_select_valid_r;
    logic [3:0]  irq_ctrl_opcode_r;
    logic        irq_ctrl_valid_r;
    logic        operand_counter_load_r;
    logic        macro_opcode_load_r;
    logic [15:0] d_bus_out_r;
    logic        d_bus_oe_n_r;

    // Force-continue flag of a word: high means the primary meaning.
    function automatic logic primary_meaning(input logic [32:0] w);
        return w[mcw_decode_pkg::FC_N_BIT];
    endfunction

    // Test select is only kept for the 11 pattern in bits 28:27.
    function automatic logic test_kept(input logic [32:0] w);
        return primary_meaning(w) &&
               (w[mcw_decode_pkg::KEEP_HI:mcw_decode_pkg::KEEP_LO] ==
                mcw_decode_pkg::TEST_KEEP_PAT);
    endfunction

    cycle_length_timer u_timer (
        .clk_sys       (clk_sys),
        .rst           (rst),
        .length_select (pipe_r[mcw_decode_pkg::CLK_LEN_HI:mcw_decode_pkg::CLK_LEN_LO]),
        .cycle_end     (cycle_end)
    );

    always_comb begin
        if (!primary_meaning(pipe_r) && pipe_r[mcw_decode_pkg::INIT_BIT]) begin
            pipe_nxt = init_word;
        end else begin
            pipe_nxt = ctrl_store_word;
        end
    end

    // The pipeline and all decoded outputs advance together at the end of a machine
    // cycle, so every decoded output stays stable for the whole stretched cycle.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pipe_r <= mcw_decode_pkg::PIPE_RESET;
        end else if (cycle_end) begin
            pipe_r <= pipe_nxt;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cycle_length_select_r <= 2'h0;
        end else if (cycle_end) begin
            cycle_length_select_r <=
                pipe_nxt[mcw_decode_pkg::CLK_LEN_HI:mcw_decode_pkg::CLK_LEN_LO];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_accept_enable_r <= 1'b0;
        end else if (cycle_end) begin
            irq_accept_enable_r <= pipe_nxt[mcw_decode_pkg::IRQ_EN_BIT];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            force_continue_n_r <= 1'b1;
        end else if (cycle_end) begin
            force_continue_n_r <= primary_meaning(pipe_nxt);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sequencer_opcode_r <= 6'h00;
        end else if (cycle_end) begin
            sequencer_opcode_r <= primary_meaning(pipe_nxt) ?
                pipe_nxt[mcw_decode_pkg::SEQ_HI:mcw_decode_pkg::SEQ_LO] : 6'h00;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            host_irq_req_r      <= 1'b0;
            a_bus_sign_extend_r <= 1'b0;
            init_strobe_r       <= 1'b0;
            irq_base_load_r     <= 1'b0;
        end else if (cycle_end) begin
            host_irq_req_r      <= !primary_meaning(pipe_nxt) &&
                                   pipe_nxt[mcw_decode_pkg::HOST_IRQ_BIT];
            a_bus_sign_extend_r <= !primary_meaning(pipe_nxt) &&
                                   pipe_nxt[mcw_decode_pkg::SIGN_EXT_BIT];
            init_strobe_r       <= !primary_meaning(pipe_nxt) &&
                                   pipe_nxt[mcw_decode_pkg::INIT_BIT];
            irq_base_load_r     <= !primary_meaning(pipe_nxt) &&
                                   pipe_nxt[mcw_decode_pkg::IRQ_BASE_BIT];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            test_select_r       <= 4'h0;
            test_select_valid_r <= 1'b0;
        end else if (cycle_end) begin
            test_select_r       <= test_kept(pipe_nxt) ?
                pipe_nxt[mcw_decode_pkg::TEST_HI:mcw_decode_pkg::TEST_LO] : 4'h0;
            test_select_valid_r <= test_kept(pipe_nxt);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_ctrl_opcode_r <= 4'h0;
            // The reset word is primary with bits 28:27 clear, so the interrupt
            // controller meaning is already in force and must read as valid.
            irq_ctrl_valid_r  <= 1'b1;
        end else if (cycle_end) begin
            irq_ctrl_opcode_r <= test_kept(pipe_nxt) ? 4'h0 :
                pipe_nxt[mcw_decode_pkg::TEST_HI:mcw_decode_pkg::TEST_LO];
            irq_ctrl_valid_r  <= !test_kept(pipe_nxt);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            operand_counter_load_r <= 1'b0;
            macro_opcode_load_r    <= 1'b0;
        end else if (cycle_end) begin
            operand_counter_load_r <= pipe_nxt[mcw_decode_pkg::OPC_LD_BIT];
            macro_opcode_load_r    <= pipe_nxt[mcw_decode_pkg::MACRO_LD_BIT];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            d_bus_out_r  <= 16'h0000;
            d_bus_oe_n_r <= 1'b1;
        end else if (cycle_end) begin
            d_bus_out_r  <= pipe_nxt[mcw_decode_pkg::BRANCH_HI:mcw_decode_pkg::BRANCH_LO];
            d_bus_oe_n_r <= pipe_nxt[mcw_decode_pkg::BRANCH_EN_N_BIT];
        end
    end

    assign machine_cycle_end    = cycle_end;
    assign pipe_word            = pipe_r;
    assign cycle_length_select  = cycle_length_select_r;
    assign irq_accept_enable    = irq_accept_enable_r;
    assign force_continue_n     = force_continue_n_r;
    assign sequencer_continue   = !force_continue_n_r;
    assign sequencer_opcode     = sequencer_opcode_r;
    assign host_irq_req         = host_irq_req_r;
    assign a_bus_sign_extend    = a_bus_sign_extend_r;
    assign init_strobe          = init_strobe_r;
    assign irq_base_load        = irq_base_load_r;
    assign test_select          = test_select_r;
    assign test_select_valid    = test_select_valid_r;
    assign irq_ctrl_opcode      = irq_ctrl_opcode_r;
    assign irq_ctrl_valid       = irq_ctrl_valid_r;
    assign operand_counter_load = operand_counter_load_r;
    assign macro_opcode_load    = macro_opcode_load_r;
    assign d_bus_out            = d_bus_out_r;
    assign d_bus_oe_n           = d_bus_oe_n_r;
endmodule // microword_control_field_decoder

// ### tb/mcw_decode_props.sv
// Concurrent checks on the ports of the control field decoder.
`timescale 1ns/1ps
module mcw_decode_props (
    input wire logic        clk_sys,             // system clock
    input wire logic        rst,                 // sync reset
    input wire logic [32:0] ctrl_store_word,     // next word
    input wire logic [32:0] init_word,           // init register
    input wire logic        machine_cycle_end,   // cycle end
    input wire logic [32:0] pipe_word,           // pipeline word
    input wire logic [1:0]  cycle_length_select, // length code
    input wire logic [5:0]  sequencer_opcode,    // seq opcode
    input wire logic        host_irq_req,        // host irq
    input wire logic        init_strobe,         // init strobe
    input wire logic [3:0]  test_select,         // test select
    input wire logic        test_select_valid,   // test meaning
    input wire logic        irq_ctrl_valid,      // irq meaning
    input wire logic [15:0] d_bus_out,           // bus data
    input wire logic        d_bus_oe_n           // bus enable
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic keep;
    assign keep = pipe_word[29] && pipe_word[28:27] == 2'h3;
    chk_next_word: assert property (machine_cycle_end && !init_strobe
        |=> pipe_word == $past(ctrl_store_word)) else $error("pipe word not loaded");
    chk_init_load: assert property (machine_cycle_end && init_strobe
        |=> pipe_word == $past(init_word)) else $error("init word not loaded");
    chk_opcode_route: assert property (pipe_word[29]
        |-> sequencer_opcode == pipe_word[28:23]) else $error("bad sequencer opcode");
    chk_alt_strobes: assert property (!pipe_word[29]
        |-> host_irq_req == pipe_word[28] && init_strobe == pipe_word[26])
        else $error("bad alternate strobes");
    chk_primary_quiet: assert property (pipe_word[29]
        |-> !host_irq_req && !init_strobe) else $error("strobe in primary meaning");
    chk_test_keep: assert property (keep
        |-> test_select_valid && test_select == pipe_word[22:19]) else $error("bad test");
    chk_irq_ctrl: assert property (!keep
        |-> irq_ctrl_valid && !test_select_valid) else $error("bad irq ctrl meaning");
    chk_bus_drive: assert property (!pipe_word[16]
        |-> !d_bus_oe_n && d_bus_out == pipe_word[15:0]) else $error("bus not driven");
    chk_bus_free: assert property (pipe_word[16] |-> d_bus_oe_n)
        else $error("bus driven while disabled");
    chk_len_short: assert property (machine_cycle_end ##1 cycle_length_select == 2'h0
        |-> !machine_cycle_end [*2] ##1 machine_cycle_end) else $error("bad short cycle");
    chk_len_double: assert property (machine_cycle_end ##1 cycle_length_select == 2'h3
        |-> !machine_cycle_end [*5] ##1 machine_cycle_end) else $error("bad double cycle");
    cover property (machine_cycle_end && init_strobe);
    cover property (!d_bus_oe_n);
    cover property (machine_cycle_end ##1 cycle_length_select == 2'h3);
endmodule // mcw_decode_props
bind microword_control_field_decoder mcw_decode_props chk (.*);

// ### tb/seq_model.sv
// Behavioural sequencer that steps its micro address under the decoded controls.
`timescale 1ns/1ps
module seq_model (
    input  wire logic       clk_sys,            // system clock
    input  wire logic       rst,                // sync reset
    input  wire logic       machine_cycle_end,  // cycle end
    input  wire logic       sequencer_continue, // continue forced
    input  wire logic [5:0] sequencer_opcode,   // instruction
    output logic [7:0]      upc_r               // micro address
);
    // Any real instruction is modelled as a jump to its code, so a missed continue shows.
    // continue when forced
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            upc_r <= 8'h00;
        end else if (machine_cycle_end) begin
            upc_r <= sequencer_continue ? upc_r + 8'h01 : {2'h0, sequencer_opcode};
        end
    end
endmodule // seq_model

// ### tb/microword_control_field_decoder_tb.sv
// Self-checking bench for the control field decoder.
`timescale 1ns/1ps
module microword_control_field_decoder_tb;
    logic clk_sys, rst, machine_cycle_end, irq_accept_enable, force_continue_n;
    logic sequencer_continue, host_irq_req, a_bus_sign_extend, init_strobe, irq_base_load;
    logic test_select_valid, irq_ctrl_valid, operand_counter_load, macro_opcode_load;
    logic d_bus_oe_n;
    logic [32:0] ctrl_store_word, init_word, pipe_word;
    logic [1:0]  cycle_length_select;
    logic [5:0]  sequencer_opcode;
    logic [3:0]  test_select, irq_ctrl_opcode;
    logic [15:0] d_bus_out;
    logic [7:0]  upc_r;
    int          n_errors = 0;
    int          total_checks = 0;
    microword_control_field_decoder DUT (.*);
    seq_model partner (.*);
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    task automatic results();
        $display("checks %0d, errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [32:0] exp, input logic [32:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask
    // Called at a falling edge; the word is taken at the next cycle end.
    task automatic put(input logic [32:0] w);
        int n;
        n = 0;
        while (machine_cycle_end !== 1'b1) begin
            @(negedge clk_sys);
            n++;
            if (n > 20) begin
                n_errors++;
                results();
            end
        end
        ctrl_store_word = w;
        @(negedge clk_sys);
    endtask
    task automatic t_primary();
        for (int k = 0; k < 4; k++) begin
            put({4'h1, k[1:0], 4'h9, 4'h5, 3'h7, 16'h1234});
            chk("opcode", {k[1:0], 4'h9}, sequencer_opcode);
            chk("test", (k == 3) ? 4'h5 : 4'h0, test_select);
            chk("test valid", k == 3, test_select_valid);
            chk("irq valid", k != 3, irq_ctrl_valid);
            chk("host irq", 1'b0, host_irq_req);
            chk("loads", 2'h3, {operand_counter_load, macro_opcode_load});
        end
    endtask
    task automatic t_alt();
        logic [7:0] u;
        put({4'h0, 4'hd, 2'h0, 4'ha, 3'h0, 16'hbeef});
        u = upc_r;
        chk("strobes", 4'hd, {host_irq_req, a_bus_sign_extend, init_strobe, irq_base_load});
        chk("irq op", {1'b1, 4'ha}, {irq_ctrl_valid, irq_ctrl_opcode});
        chk("continue", {1'b1, 1'b0, 6'h00}, {sequencer_continue, force_continue_n, sequencer_opcode});
        chk("alt quiet", 3'h0, {irq_accept_enable, operand_counter_load, macro_opcode_load});
        chk("bus", {1'b0, 16'hbeef}, {d_bus_oe_n, d_bus_out});
        put({4'h1, 29'h10000});
        chk("micro address", u + 8'h01, upc_r);
    endtask
    task automatic t_len();
        int n;
        for (int c = 0; c < 4; c++) begin
            put({c[1:0], 2'h3, 29'h10000});
            chk("irq enable", 1'b1, irq_accept_enable);
            chk("length code", c[1:0], cycle_length_select);
            chk("bus off", 1'b1, d_bus_oe_n);
            n = 1;
            while (machine_cycle_end !== 1'b1 && n < 10) begin
                @(negedge clk_sys);
                n++;
            end
            chk("cycle length", mcw_decode_pkg::TICKS_NORMAL + c, n);
            if (n >= 10) begin
                results();
            end
        end
    endtask
    task automatic t_init();
        init_word = {4'h3, 29'h12345};
        put({4'h0, 4'h2, 25'h0010000});
        chk("init strobe", 1'b1, init_strobe);
        put({4'h1, 29'h00abc});
        chk("pipe word", init_word, pipe_word);
    endtask
    initial begin
        rst = 1'b1;
        ctrl_store_word = 33'h000000000;
        init_word = 33'h000000000;
        repeat (10) @(negedge clk_sys);
        rst = 1'b0;
        chk("reset word", mcw_decode_pkg::PIPE_RESET, pipe_word);
        chk("reset flags", 2'h3, {force_continue_n, d_bus_oe_n});
        chk("reset irq valid", 1'b1, irq_ctrl_valid);
        t_primary();
        t_alt();
        t_len();
        t_init();
        results();
    end
endmodule // microword_control_field_decoder_tb
